/* hw/itr_pkg.sv */
`default_nettype none
package itr_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_SCL_LOW_PERIOD = 8'h0B;
   localparam logic [7:0] ADDR_RESERVED_SPARE = 8'h0C;
   localparam logic [7:0] ADDR_IO_VOLTAGE_CONTROL = 8'h0D;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_SCL_LOW_PERIOD = 8'h7A;
   localparam logic [7:0] RST_RESERVED_SPARE = 8'h00;
   localparam logic [3:0] RST_IO_VOLTAGE_CONTROL_SPARE = 4'h9;
   localparam logic [7:0] RDATA_NONE = 8'h00;

   // ---------------------------------------------------------------
   // supply level encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] SUPPLY_1V8 = 2'h0;
   localparam logic [1:0] SUPPLY_3V3 = 2'h3;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int SYS_PERIOD_NS = 5;
   localparam int OSC_PERIOD_NS = 40;
   localparam int OSC_TICK_CYC_INT = (OSC_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam logic [2:0] OSC_TICK_LAST = 3'(OSC_TICK_CYC_INT - 1);
   localparam logic [8:0] LOW_EXTRA_TICKS = 9'h004;
   localparam logic [8:0] PHASE_ONE = 9'h001;

   // ---------------------------------------------------------------
   // io voltage control layout, bit 7 down to bit 0
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       high_voltage_select;
      logic       supply_level_override;
      logic [1:0] supply_mode;
      logic [3:0] spare;
   } itr_io_voltage_control_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } itr_reg_req_t;
endpackage : itr_pkg
`default_nettype wire

/* hw/itr_low_timer.sv */
`default_nettype none
module itr_low_timer (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic start_i,
   input wire logic [7:0] count_i,
   output logic busy_o,
   output logic done_o
);
   // ---------------------------------------------------------------
   // oscillator tick and phase counters
   // ---------------------------------------------------------------
   logic [2:0] tick_r;
   logic [8:0] left_r;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         tick_r <= '0;
         left_r <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (!busy_o) begin
            if (start_i) begin
               busy_o <= 1'b1;
               tick_r <= '0;
               left_r <= {1'b0, count_i} + itr_pkg::LOW_EXTRA_TICKS;
            end
         end else if (tick_r == itr_pkg::OSC_TICK_LAST) begin
            tick_r <= '0;
            if (left_r == itr_pkg::PHASE_ONE) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
               left_r <= '0;
            end else begin
               left_r <= left_r - itr_pkg::PHASE_ONE;
            end
         end else begin
            tick_r <= tick_r + 3'h1;
         end
      end
   end
endmodule : itr_low_timer
`default_nettype wire

/* hw/itr_regs.sv */
`default_nettype none
module itr_regs (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic io_supply_rail_3p3_i,
   input wire logic scl_low_start_i,
   output logic scl_drive_low_o,
   output logic scl_low_done_o,
   input wire logic setup_start_i,
   output logic setup_hold_scl_o,
   output logic setup_done_o,
   output logic io_high_voltage_select_o,
   output logic [1:0] io_supply_mode_o
);
   // ---------------------------------------------------------------
   // request bundle
   // ---------------------------------------------------------------
   itr_pkg::itr_reg_req_t req;
   assign req = '{addr: reg_addr_i, wr: reg_wr_i, rd: reg_rd_i, wdata: reg_wdata_i};

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   logic hit_low_period;
   logic hit_reserved_spare;
   logic hit_io_voltage_control;
   logic wr_low_period;
   logic wr_reserved_spare;
   logic wr_io_voltage_control;

   assign hit_low_period = (req.addr == itr_pkg::ADDR_SCL_LOW_PERIOD);
   assign hit_reserved_spare = (req.addr == itr_pkg::ADDR_RESERVED_SPARE);
   assign hit_io_voltage_control = (req.addr == itr_pkg::ADDR_IO_VOLTAGE_CONTROL);

   assign wr_low_period = req.wr && hit_low_period;
   assign wr_reserved_spare = req.wr && hit_reserved_spare;
   assign wr_io_voltage_control = req.wr && hit_io_voltage_control;

   // ---------------------------------------------------------------
   // detected supply synchroniser
   // ---------------------------------------------------------------
   logic rail_meta_r;
   logic rail_sync_r;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rail_meta_r <= 1'b0;
         rail_sync_r <= 1'b0;
      end else begin
         rail_meta_r <= io_supply_rail_3p3_i;
         rail_sync_r <= rail_meta_r;
      end
   end

   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   logic [7:0] scl_low_period_r;
   logic [7:0] reserved_spare_r;
   itr_pkg::itr_io_voltage_control_t io_voltage_control_r;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         scl_low_period_r <= itr_pkg::RST_SCL_LOW_PERIOD;
      end else if (wr_low_period) begin
         scl_low_period_r <= req.wdata;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         reserved_spare_r <= itr_pkg::RST_RESERVED_SPARE;
      end else if (wr_reserved_spare) begin
         reserved_spare_r <= req.wdata;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         io_voltage_control_r.high_voltage_select <= 1'b0;
         io_voltage_control_r.supply_level_override <= 1'b0;
         io_voltage_control_r.supply_mode <= itr_pkg::SUPPLY_1V8;
         io_voltage_control_r.spare <= itr_pkg::RST_IO_VOLTAGE_CONTROL_SPARE;
      end else if (wr_io_voltage_control) begin
         io_voltage_control_r <= itr_pkg::itr_io_voltage_control_t'(req.wdata);
      end
   end

   // ---------------------------------------------------------------
   // detected level encoding
   // ---------------------------------------------------------------
   logic det_sel;
   logic [1:0] det_mode;

   always_comb begin
      det_sel = rail_sync_r;
      det_mode = itr_pkg::SUPPLY_1V8;
      if (rail_sync_r) begin
         det_mode = itr_pkg::SUPPLY_3V3;
      end
   end

   // ---------------------------------------------------------------
   // effective supply controls
   // ---------------------------------------------------------------
   logic eff_sel;
   logic [1:0] eff_mode;

   always_comb begin
      if (io_voltage_control_r.supply_level_override) begin
         eff_sel = io_voltage_control_r.high_voltage_select;
         eff_mode = io_voltage_control_r.supply_mode;
      end else begin
         eff_sel = det_sel;
         eff_mode = det_mode;
      end
   end

   // ---------------------------------------------------------------
   // output registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         io_high_voltage_select_o <= 1'b0;
         io_supply_mode_o <= itr_pkg::SUPPLY_1V8;
      end else begin
         io_high_voltage_select_o <= eff_sel;
         io_supply_mode_o <= eff_mode;
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   itr_pkg::itr_io_voltage_control_t io_voltage_control_view;

   always_comb begin
      io_voltage_control_view = io_voltage_control_r;
      io_voltage_control_view.high_voltage_select = eff_sel;
      io_voltage_control_view.supply_mode = eff_mode;
   end

   logic [7:0] rdata_nxt;

   always_comb begin
      case (req.addr)
         itr_pkg::ADDR_SCL_LOW_PERIOD: begin
            rdata_nxt = scl_low_period_r;
         end
         itr_pkg::ADDR_RESERVED_SPARE: begin
            rdata_nxt = reserved_spare_r;
         end
         itr_pkg::ADDR_IO_VOLTAGE_CONTROL: begin
            rdata_nxt = io_voltage_control_view;
         end
         default: begin
            rdata_nxt = itr_pkg::RDATA_NONE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= itr_pkg::RDATA_NONE;
      end else if (req.rd) begin
         reg_rdata_o <= rdata_nxt;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= req.rd;
      end
   end

   // ---------------------------------------------------------------
   // low phase timers: channel 0 master clock low, channel 1 target set-up
   // ---------------------------------------------------------------
   localparam int TIMER_CH = 2;

   logic [TIMER_CH-1:0] tmr_start;
   logic [TIMER_CH-1:0] tmr_busy;
   logic [TIMER_CH-1:0] tmr_done;

   assign tmr_start = {setup_start_i, scl_low_start_i};

   generate
      for (genvar ch = 0; ch < TIMER_CH; ch++) begin : g_timer
         itr_low_timer u_timer (
            .clk_sys_i(clk_sys_i),
            .sys_rst_i(sys_rst_i),
            .start_i(tmr_start[ch]),
            .count_i(scl_low_period_r),
            .busy_o(tmr_busy[ch]),
            .done_o(tmr_done[ch])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // timer outputs
   // ---------------------------------------------------------------
   assign scl_drive_low_o = tmr_busy[0];
   assign scl_low_done_o = tmr_done[0];
   assign setup_hold_scl_o = tmr_busy[1];
   assign setup_done_o = tmr_done[1];
endmodule : itr_regs
`default_nettype wire

/* verification/itr_regs_checker.sv */
`default_nettype none
module itr_regs_checker (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic io_supply_rail_3p3_i,
   input wire logic scl_drive_low_o,
   input wire logic scl_low_done_o,
   input wire logic setup_hold_scl_o,
   input wire logic setup_done_o,
   input wire logic io_high_voltage_select_o,
   input wire logic [1:0] io_supply_mode_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] lo_r;
   logic [7:0] ctl_r;
   logic rd_io_r;
   logic [15:0] low_run_r;
   logic [15:0] set_run_r;
   logic [15:0] exp_run;
   assign exp_run = ({8'h00, lo_r} + 16'h0004) * 16'h0008;
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         lo_r <= itr_pkg::RST_SCL_LOW_PERIOD;
         ctl_r <= 8'h09;
      end else if (reg_wr_i && reg_addr_i == itr_pkg::ADDR_SCL_LOW_PERIOD) begin
         lo_r <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == itr_pkg::ADDR_IO_VOLTAGE_CONTROL) begin
         ctl_r <= reg_wdata_i;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      rd_io_r <= reg_rd_i && reg_addr_i == itr_pkg::ADDR_IO_VOLTAGE_CONTROL;
      low_run_r <= scl_drive_low_o ? low_run_r + 16'h0001 : 16'h0000;
      set_run_r <= setup_hold_scl_o ? set_run_r + 16'h0001 : 16'h0000;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   a_low_len: assert property (scl_low_done_o |-> low_run_r == exp_run) else $error("low phase length");
   a_setup_len: assert property (setup_done_o |-> set_run_r == exp_run) else $error("setup length");
   a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("no read answer");
   a_unmapped_zero: assert property (reg_rd_i && !(reg_addr_i inside {[8'h0B:8'h0D]}) |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_follow_rail: assert property ((!ctl_r[6] && $stable(io_supply_rail_3p3_i))[*5] |->
      io_high_voltage_select_o == io_supply_rail_3p3_i && io_supply_mode_o == {2{io_supply_rail_3p3_i}})
      else $error("controls not following rail");
   a_apply_write: assert property ((ctl_r[6] && !reg_wr_i)[*3] |->
      io_high_voltage_select_o == ctl_r[7] && io_supply_mode_o == ctl_r[5:4]) else $error("override not applied");
   a_read_detected: assert property (reg_rvalid_o && rd_io_r && !ctl_r[6] |->
      reg_rdata_o[7] == io_high_voltage_select_o && reg_rdata_o[5:4] == io_supply_mode_o)
      else $error("read not detected level");
   c_low_done: cover property (scl_low_done_o);
   c_setup_done: cover property (setup_done_o);
   c_override: cover property (ctl_r[6] && io_supply_mode_o == 2'h1);
endmodule : itr_regs_checker
bind itr_regs itr_regs_checker u_chk (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
   .reg_rdata_o, .reg_rvalid_o, .io_supply_rail_3p3_i, .scl_drive_low_o, .scl_low_done_o, .setup_hold_scl_o,
   .setup_done_o, .io_high_voltage_select_o, .io_supply_mode_o);
`default_nettype wire

/* verification/itr_scl_target.sv */
`default_nettype none
module itr_scl_target (
   input wire logic clk_sys_i,
   input wire logic scl_drive_low_i,
   output logic scl_line_o,
   output logic [15:0] low_width_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] run_r = 16'h0000;
   // pulled-up clock line, low only while driven
   assign scl_line_o = !scl_drive_low_i;
   // target side measures each low phase it sees
   always @(posedge clk_sys_i) begin
      if (!scl_line_o) begin
         run_r <= run_r + 16'h0001;
      end else begin
         if (run_r != 16'h0000) low_width_o <= run_r;
         run_r <= 16'h0000;
      end
   end
endmodule : itr_scl_target
`default_nettype wire

/* verification/tb_top.sv */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rail = 1'b0;
   logic scl_low_start_i = 1'b0, setup_start_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
   logic reg_rvalid_o, scl_drive_low_o, scl_low_done_o, setup_hold_scl_o, setup_done_o, sel, scl_line;
   logic [1:0] mode;
   logic [15:0] low_width;
   logic [15:0] dflt = ({8'h00, itr_pkg::RST_SCL_LOW_PERIOD} + 16'h0004) * 16'h0008;
   int err_count = 0, check_count = 0, cyc = 0;
   itr_regs u_dut (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
      .reg_rvalid_o, .io_supply_rail_3p3_i(rail), .scl_low_start_i, .scl_drive_low_o, .scl_low_done_o,
      .setup_start_i, .setup_hold_scl_o, .setup_done_o, .io_high_voltage_select_o(sel), .io_supply_mode_o(mode));
   itr_scl_target u_tgt (.clk_sys_i, .scl_drive_low_i(scl_drive_low_o), .scl_line_o(scl_line),
      .low_width_o(low_width));
   always #2.5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         $display("mismatch %0t timeout", $time);
         end_of_test();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1;
      chk({15'h0000, reg_rvalid_o}, 16'h0001, "no read answer");
      chk({8'h00, reg_rdata_o}, {8'h00, exp}, "read data");
   endtask : rdc
   task automatic run(input bit s, input logic [15:0] exp);
      int n;
      logic [15:0] c;
      n = 0;
      c = 16'h0000;
      @(posedge clk_sys_i);
      if (s) setup_start_i <= 1'b1;
      else scl_low_start_i <= 1'b1;
      @(posedge clk_sys_i);
      setup_start_i <= 1'b0;
      scl_low_start_i <= 1'b0;
      #1;
      while ((s ? setup_done_o : scl_low_done_o) !== 1'b1 && n < 3000) begin
         if ((s ? setup_hold_scl_o : scl_drive_low_o) === 1'b1) c++;
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      chk(c, exp, "phase length");
   endtask : run
   task automatic ovr(input logic [7:0] d, input logic [2:0] exp, input logic [7:0] rb);
      wr(itr_pkg::ADDR_IO_VOLTAGE_CONTROL, d);
      repeat (5) @(posedge clk_sys_i);
      #1;
      chk({13'h0000, sel, mode}, {13'h0000, exp}, "effective controls");
      rdc(itr_pkg::ADDR_IO_VOLTAGE_CONTROL, rb);
   endtask : ovr
   task automatic end_of_test();
      if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (10) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      rdc(itr_pkg::ADDR_SCL_LOW_PERIOD, itr_pkg::RST_SCL_LOW_PERIOD);
      rdc(itr_pkg::ADDR_IO_VOLTAGE_CONTROL, {2'h0, itr_pkg::SUPPLY_1V8, itr_pkg::RST_IO_VOLTAGE_CONTROL_SPARE});
      wr(itr_pkg::ADDR_RESERVED_SPARE, 8'hA5);
      rdc(itr_pkg::ADDR_RESERVED_SPARE, 8'hA5);
      wr(8'h0E, 8'hFF);
      rdc(8'h0E, 8'h00);
      run(1'b0, dflt);
      @(posedge clk_sys_i);
      #1;
      chk(low_width, dflt, "target low width");
      chk({15'h0000, scl_line}, 16'h0001, "clock not released");
      wr(itr_pkg::ADDR_SCL_LOW_PERIOD, 8'h00);
      run(1'b1, 16'h0020);
      run(1'b0, 16'h0020);
      @(posedge clk_sys_i);
      #1;
      chk(low_width, 16'h0020, "target low width");
      @(posedge clk_sys_i);
      rail <= 1'b1;
      ovr(8'h09, {1'b1, itr_pkg::SUPPLY_3V3}, 8'hB9);
      ovr(8'h59, 3'h1, 8'h59);
      ovr(8'h09, {1'b1, itr_pkg::SUPPLY_3V3}, 8'hB9);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
